//--- fia_pkg.sv
// constants for the flash in-application programming controller
package fia_pkg;
    // special register addresses, low byte of the data memory address
    localparam logic [7:0] ADDR_CTRL_MAIN   = 8'h6D;
    localparam logic [7:0] ADDR_CTRL_CHIPRST = 8'h6E;
    localparam logic [7:0] ADDR_CTRL_BUFCLR = 8'h6F;
    localparam logic [7:0] ADDR_ADDR_LOW    = 8'h70;
    localparam logic [7:0] ADDR_ADDR_HIGH   = 8'h71;
    localparam logic [7:0] ADDR_DATA_FIRST  = 8'h72;
    localparam logic [7:0] ADDR_DATA_LAST   = 8'h79;
    localparam logic [7:0] ADDR_PATTERN_FIRST = 8'h74;
    localparam logic [3:0] CTRL_SECTOR      = 4'h1;
    localparam int         DATA_BYTES       = 8;

    // flash_ctrl_main field positions
    localparam int BIT_UNLOCKED = 7;
    localparam int MODE_HI      = 6;
    localparam int MODE_LO      = 4;
    localparam int BIT_PROC_EN  = 3;
    localparam int BIT_WRITE    = 2;
    localparam int BIT_RDEN     = 1;
    localparam int BIT_READ     = 0;
    localparam int BIT_BUFCLR   = 0;

    // operation_select_field codes
    localparam logic [2:0] MODE_WRITE  = 3'h0;
    localparam logic [2:0] MODE_ERASE  = 3'h1;
    localparam logic [2:0] MODE_READ   = 3'h3;
    localparam logic [2:0] MODE_UNLOCK = 3'h6;

    localparam logic [7:0] RESET_BYTE     = 8'h00;
    localparam logic [7:0] CHIP_RESET_KEY = 8'h55;

    // unlock pattern, byte i at [8*i +: 8]
    localparam logic [47:0] UNLOCK_PATTERN = 48'h40C3090D0400;
    localparam logic [2:0]  PATTERN_LAST   = 3'h5;

    // unlock timeout, counted on slow_internal_oscillator ticks
    localparam longint TIMEOUT_US    = 300;
    localparam longint SLOW_OSC_HZ   = 32000;
    localparam logic [3:0] TIMEOUT_TICKS = 4'((TIMEOUT_US * SLOW_OSC_HZ) / 1000000);

    // address high widths per variant
    localparam logic [7:0] ADDR_HIGH_MASK_SMALL = 8'h1F;
    localparam logic [7:0] ADDR_HIGH_MASK_LARGE = 8'h3F;
endpackage

//--- fia_flash_iap.sv
// flash in-application programming: unlock sequence, registers, operation launch
//
// What this block does
// - enable bit may be set together with the mode code in one write
// - starting the procedure arms a 300 us timeout; pattern must finish before it
// - timeout counts ticks of the slow internal oscillator, not the system clock
// - overflow or wrong byte leaves writes locked and clears the enable bit
// - correct pattern in time unlocks, clears enable bit, sets unlocked flag
// - flash modifying operations are allowed only while the unlocked flag is set
// - software clearing the unlocked flag re-locks flash writing
// - erase page is 32 words on small variant, 64 on large variant
// - small variant page is address high over address low bits 7..5
// - large variant page is address high over address low bits 7..6
// - processor halted while write or read trigger bit is one
// - third data word low/high bytes readable, writable, reset to zero
// - fourth data word low/high bytes readable, writable, reset to zero
// - the three control registers respond only in data memory sector 1
// - mode codes decode write, page erase, read, unlock; others reserved
// - software writing one to the unlocked flag does nothing
// - write trigger set by software only, cleared by hardware on completion
`timescale 1ns/1ps
module fia_flash_iap #(
    parameter bit LARGE_VARIANT = 1'b0
) (
    input  wire logic        core_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        slow_osc_tick_in,
    input  wire logic [3:0]  sfr_sector_in,
    input  wire logic [7:0]  sfr_addr_in,
    input  wire logic        sfr_wr_in,
    input  wire logic [7:0]  sfr_wdata_in,
    output logic      [7:0]  sfr_rdata_out,
    input  wire logic        flash_done_in,
    input  wire logic [15:0] flash_rdata_in,
    output logic             flash_write_out,
    output logic             flash_erase_out,
    output logic             flash_read_out,
    output logic      [13:0] flash_addr_out,
    output logic      [7:0]  flash_page_out,
    output logic      [63:0] flash_wdata_out,
    output logic             write_buf_clear_out,
    output logic             chip_reset_out,
    output logic             cpu_stall_out,
    output logic             write_unlocked_out
);

    typedef enum logic {UL_IDLE, UL_ARMED} fia_unlock_e;

    ////////////////////////////////////////////////////////////////////////////////
    // decode helpers

    // control registers live only in one sector
    function automatic logic in_ctrl_space(input logic [7:0] a, input logic [3:0] s);
        in_ctrl_space = (s == fia_pkg::CTRL_SECTOR) &&
                        (a >= fia_pkg::ADDR_CTRL_MAIN) && (a <= fia_pkg::ADDR_CTRL_BUFCLR);
    endfunction

    // erase page number from the address pair
    function automatic logic [7:0] page_of(input logic [7:0] hi, input logic [7:0] lo);
        if (LARGE_VARIANT) begin
            page_of = {hi[5:0], lo[7:6]};
        end else begin
            page_of = {hi[4:0], lo[7:5]};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // state

    logic              unlocked;
    logic [2:0]        mode_sel;
    logic              proc_en;
    logic              wr_trig;
    logic              rd_en;
    logic              rd_trig;
    logic              buf_clr;
    logic [7:0]        addr_low;
    logic [7:0]        addr_high;
    logic [7:0]        data_byte [0:fia_pkg::DATA_BYTES-1];
    fia_unlock_e       ul_state;
    logic [2:0]        ul_idx;
    logic [3:0]        ul_ticks;
    logic              op_busy;
    logic              op_read;

    ////////////////////////////////////////////////////////////////////////////////
    // write decode

    wire        ctrl_ok     = in_ctrl_space(sfr_addr_in, sfr_sector_in);
    wire        wr_main     = sfr_wr_in && ctrl_ok && (sfr_addr_in == fia_pkg::ADDR_CTRL_MAIN);
    wire        wr_chiprst  = sfr_wr_in && ctrl_ok && (sfr_addr_in == fia_pkg::ADDR_CTRL_CHIPRST);
    wire        wr_bufclr   = sfr_wr_in && ctrl_ok && (sfr_addr_in == fia_pkg::ADDR_CTRL_BUFCLR);
    wire        wr_alow     = sfr_wr_in && (sfr_addr_in == fia_pkg::ADDR_ADDR_LOW);
    wire        wr_ahigh    = sfr_wr_in && (sfr_addr_in == fia_pkg::ADDR_ADDR_HIGH);
    wire [2:0]  wr_mode     = sfr_wdata_in[fia_pkg::MODE_HI:fia_pkg::MODE_LO];
    wire [7:0]  high_mask   = LARGE_VARIANT ? fia_pkg::ADDR_HIGH_MASK_LARGE
                                            : fia_pkg::ADDR_HIGH_MASK_SMALL;

    ////////////////////////////////////////////////////////////////////////////////
    // unlock sequence decode

    // mode and enable accepted in the same write
    wire ul_start   = wr_main && sfr_wdata_in[fia_pkg::BIT_PROC_EN]
                      && (wr_mode == fia_pkg::MODE_UNLOCK);
    wire ul_abort   = wr_main && !sfr_wdata_in[fia_pkg::BIT_PROC_EN];
    wire pat_wr     = sfr_wr_in && (sfr_addr_in >= fia_pkg::ADDR_PATTERN_FIRST)
                      && (sfr_addr_in <= fia_pkg::ADDR_DATA_LAST);
    wire [7:0] exp_addr = fia_pkg::ADDR_PATTERN_FIRST + {5'h00, ul_idx};
    wire [7:0] exp_data = fia_pkg::UNLOCK_PATTERN[{ul_idx, 3'h0} +: 8];
    // wrong register or wrong value both fail the attempt
    wire pat_match  = (sfr_addr_in == exp_addr) && (sfr_wdata_in == exp_data);
    wire armed      = (ul_state == UL_ARMED);
    wire ul_timeout = armed && slow_osc_tick_in
                      && (ul_ticks == fia_pkg::TIMEOUT_TICKS - 4'h1);
    wire ul_success = armed && !ul_timeout && pat_wr && pat_match
                      && (ul_idx == fia_pkg::PATTERN_LAST);
    wire ul_fail    = armed && (ul_timeout || (pat_wr && !pat_match));

    ////////////////////////////////////////////////////////////////////////////////
    // operation launch decode

    // reserved mode codes launch nothing and the trigger just drops
    wire mode_modify = (mode_sel == fia_pkg::MODE_WRITE) || (mode_sel == fia_pkg::MODE_ERASE);
    wire mode_rd     = (mode_sel == fia_pkg::MODE_READ);
    wire wr_allowed  = unlocked && mode_modify;
    wire rd_allowed  = rd_en && mode_rd;
    wire launch_wr   = !op_busy && wr_trig && wr_allowed;
    wire launch_rd   = !op_busy && !wr_trig && rd_trig && rd_allowed;
    wire reject_wr   = !op_busy && wr_trig && !wr_allowed;
    wire reject_rd   = !op_busy && !wr_trig && rd_trig && !rd_allowed;
    wire op_finish   = op_busy && flash_done_in;

    ////////////////////////////////////////////////////////////////////////////////
    // next values for flash_ctrl_main

    // hardware set wins; software can only clear the flag
    wire next_unlocked = ul_success ? 1'b1 :
                         (wr_main && !sfr_wdata_in[fia_pkg::BIT_UNLOCKED]) ? 1'b0 :
                         unlocked;
    wire next_proc_en  = (ul_success || (ul_fail && !ul_start)) ? 1'b0 :
                         wr_main ? sfr_wdata_in[fia_pkg::BIT_PROC_EN] : proc_en;
    // software set wins over a completion in the same cycle
    wire next_wr_trig  = (wr_main && sfr_wdata_in[fia_pkg::BIT_WRITE]) ? 1'b1 :
                         ((op_finish && !op_read) || reject_wr) ? 1'b0 : wr_trig;
    wire next_rd_trig  = (wr_main && sfr_wdata_in[fia_pkg::BIT_READ]) ? 1'b1 :
                         ((op_finish && op_read) || reject_rd) ? 1'b0 : rd_trig;

    ////////////////////////////////////////////////////////////////////////////////
    // control register

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            unlocked <= 1'b0;
            mode_sel <= 3'h0;
            proc_en  <= 1'b0;
            wr_trig  <= 1'b0;
            rd_en    <= 1'b0;
            rd_trig  <= 1'b0;
        end else begin
            unlocked <= next_unlocked;
            proc_en  <= next_proc_en;
            wr_trig  <= next_wr_trig;
            rd_trig  <= next_rd_trig;
            if (wr_main) begin
                mode_sel <= wr_mode;
                rd_en    <= sfr_wdata_in[fia_pkg::BIT_RDEN];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // unlock sequencer, timeout on slow oscillator enable ticks

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ul_state <= UL_IDLE;
            ul_idx   <= 3'h0;
            ul_ticks <= 4'h0;
        end else if (ul_start) begin
            ul_state <= UL_ARMED;
            ul_idx   <= 3'h0;
            ul_ticks <= 4'h0;
        end else begin
            case (ul_state)
                UL_IDLE: begin
                    ul_idx <= 3'h0;
                end
                UL_ARMED: begin
                    if (ul_fail || ul_success || ul_abort) begin
                        ul_state <= UL_IDLE;
                    end else begin
                        if (pat_wr) begin
                            ul_idx <= ul_idx + 3'h1;
                        end
                        if (slow_osc_tick_in) begin
                            ul_ticks <= ul_ticks + 4'h1;
                        end
                    end
                end
                default: begin
                    ul_state <= UL_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // address, buffer clear and chip reset strobes

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            addr_low            <= fia_pkg::RESET_BYTE;
            addr_high           <= fia_pkg::RESET_BYTE;
            buf_clr             <= 1'b0;
            write_buf_clear_out <= 1'b0;
            chip_reset_out      <= 1'b0;
        end else begin
            if (wr_alow) begin
                addr_low <= sfr_wdata_in;
            end
            if (wr_ahigh) begin
                addr_high <= sfr_wdata_in & high_mask;
            end
            // buffer clear finishes in one cycle, so the bit reads back one once
            buf_clr             <= wr_bufclr && sfr_wdata_in[fia_pkg::BIT_BUFCLR];
            write_buf_clear_out <= wr_bufclr && sfr_wdata_in[fia_pkg::BIT_BUFCLR];
            chip_reset_out      <= wr_chiprst && (sfr_wdata_in == fia_pkg::CHIP_RESET_KEY);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // data word bytes; the first word also catches read results

    genvar gi;
    generate
        for (gi = 0; gi < fia_pkg::DATA_BYTES; gi++) begin : g_data
            localparam logic [7:0] MY_ADDR = fia_pkg::ADDR_DATA_FIRST + 8'(gi);
            always_ff @(posedge core_clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    data_byte[gi] <= fia_pkg::RESET_BYTE;
                end else if (op_finish && op_read && (gi < 2)) begin
                    data_byte[gi] <= flash_rdata_in[8*(gi%2) +: 8];
                end else if (sfr_wr_in && (sfr_addr_in == MY_ADDR)) begin
                    data_byte[gi] <= sfr_wdata_in;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // flash operation engine

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            op_busy         <= 1'b0;
            op_read         <= 1'b0;
            flash_write_out <= 1'b0;
            flash_erase_out <= 1'b0;
            flash_read_out  <= 1'b0;
        end else begin
            flash_write_out <= launch_wr && (mode_sel == fia_pkg::MODE_WRITE);
            flash_erase_out <= launch_wr && (mode_sel == fia_pkg::MODE_ERASE);
            flash_read_out  <= launch_rd;
            if (launch_wr || launch_rd) begin
                op_busy <= 1'b1;
                op_read <= launch_rd;
            end else if (op_finish) begin
                op_busy <= 1'b0;
            end
        end
    end

    // erase page selects by variant; low bits below the page are ignored
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flash_addr_out  <= 14'h0000;
            flash_page_out  <= 8'h00;
            flash_wdata_out <= 64'h0000000000000000;
        end else begin
            flash_addr_out  <= {addr_high[5:0], addr_low};
            flash_page_out  <= page_of(addr_high, addr_low);
            flash_wdata_out <= {data_byte[7], data_byte[6], data_byte[5], data_byte[4],
                                data_byte[3], data_byte[2], data_byte[1], data_byte[0]};
        end
    end

    // processor held while either trigger is pending
    assign cpu_stall_out      = wr_trig || rd_trig;
    assign write_unlocked_out = unlocked;

    ////////////////////////////////////////////////////////////////////////////////
    // read-back, registered; unmapped or hidden addresses read zero

    wire [7:0] main_val = {unlocked, mode_sel, proc_en, wr_trig, rd_en, rd_trig};
    wire [7:0] data_val = data_byte[3'(sfr_addr_in - fia_pkg::ADDR_DATA_FIRST)];
    wire       is_data  = (sfr_addr_in >= fia_pkg::ADDR_DATA_FIRST)
                          && (sfr_addr_in <= fia_pkg::ADDR_DATA_LAST);
    wire [7:0] rd_val   =
        (ctrl_ok && sfr_addr_in == fia_pkg::ADDR_CTRL_MAIN)   ? main_val :
        (ctrl_ok && sfr_addr_in == fia_pkg::ADDR_CTRL_BUFCLR) ? {7'h00, buf_clr} :
        (sfr_addr_in == fia_pkg::ADDR_ADDR_LOW)                ? addr_low :
        (sfr_addr_in == fia_pkg::ADDR_ADDR_HIGH)               ? addr_high :
        is_data                                                ? data_val : 8'h00;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sfr_rdata_out <= 8'h00;
        end else begin
            sfr_rdata_out <= rd_val;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    AST_UNLOCK_SUCCESS: assert property (
        ul_success |=> unlocked && !proc_en && ul_state == UL_IDLE)
        else $error("unlock success did not set flag and clear enable");
    AST_FAIL_LOCKED: assert property (
        (ul_fail && !ul_start && !unlocked) |=> !unlocked && !proc_en)
        else $error("failed unlock left enable set or unlocked");
    AST_SW_SET_IGNORED: assert property (
        (!unlocked && !ul_success) |=> !unlocked)
        else $error("unlocked flag rose without the sequence");
    AST_SW_RELOCK: assert property (
        (wr_main && !sfr_wdata_in[fia_pkg::BIT_UNLOCKED] && !ul_success) |=> !unlocked)
        else $error("clearing the unlocked flag did not re-lock");
    AST_MODIFY_NEEDS_UNLOCK: assert property (
        (flash_write_out || flash_erase_out) |-> $past(unlocked))
        else $error("flash modified while locked");
    AST_STALL: assert property (
        (op_busy || $rose(wr_trig) || $rose(rd_trig)) |-> cpu_stall_out)
        else $error("processor not stalled during operation");
    AST_SECTOR_GATE: assert property (
        (sfr_wr_in && sfr_addr_in == fia_pkg::ADDR_CTRL_MAIN
         && sfr_sector_in != fia_pkg::CTRL_SECTOR && !ul_success && !op_busy
         && !wr_trig && !rd_trig && !armed) |=> $stable(main_val))
        else $error("control register changed outside its sector");
    AST_RESTART: assert property (
        ul_start |=> armed && ul_idx == 3'h0 && ul_ticks == 4'h0)
        else $error("unlock start did not restart the sequence");
    AST_TIMEOUT_BOUND: assert property (
        armed |-> ul_ticks < fia_pkg::TIMEOUT_TICKS)
        else $error("timeout counter passed its limit");
    AST_TRIGGER_CLEAR: assert property (
        (op_finish && !op_read && !wr_main) |=> !wr_trig)
        else $error("write trigger not cleared on completion");
    AST_PAGE_SMALL: assert property (
        !LARGE_VARIANT |=> flash_page_out == {$past(addr_high[4:0]), $past(addr_low[7:5])})
        else $error("small variant page number wrong");

    COV_UNLOCK: cover property (ul_success);
    COV_TIMEOUT: cover property (ul_timeout);
    COV_BAD_BYTE: cover property (armed && pat_wr && !pat_match);
    COV_ERASE: cover property (flash_erase_out);

endmodule // fia_flash_iap

//--- fia_flash_model.sv
// behavioural model of the program flash array behind the controller
`timescale 1ns/1ps
module fia_flash_model #(
    parameter int          BUSY_CYCLES = 6,
    parameter logic [15:0] READ_WORD   = 16'hBEEF
) (
    input  wire logic        core_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        flash_write_in,
    input  wire logic        flash_erase_in,
    input  wire logic        flash_read_in,
    output logic             flash_done_out,
    output logic      [15:0] flash_rdata_out
);
    logic [7:0] busy_cnt;
    ////////////////////////////////////////////////////////////////////////////
    // busy countdown, restarted by any launch pulse
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) busy_cnt <= 8'h00;
        else if (flash_write_in | flash_erase_in | flash_read_in) busy_cnt <= 8'(BUSY_CYCLES);
        else if (busy_cnt != 8'h00) busy_cnt <= busy_cnt - 8'h01;
    end
    // one-cycle completion; data bus shows garbage outside it so stale values never pass
    assign flash_done_out  = (busy_cnt == 8'h01);
    assign flash_rdata_out = flash_done_out ? READ_WORD : ~READ_WORD;
endmodule // fia_flash_model

//--- fia_flash_iap_tb.sv
// self-checking testbench for the flash programming controller
`timescale 1ns/1ps
module fia_flash_iap_tb;
    logic        clk = 1'b0, rst_n = 1'b0, tick = 1'b0, wr = 1'b0;
    logic [3:0]  sec = 4'h1;
    logic [7:0]  addr = 8'h00, wdata = 8'h00;
    logic [7:0]  rdata, page;
    logic [13:0] faddr;
    logic [63:0] fwdata;
    logic [15:0] frdata;
    logic        f_wr, f_er, f_rd, f_done, bclr, crst, stall, unl;
    int          fails = 0, tests_run = 0;
    ////////////////////////////////////////////////////////////////////////////
    // clock at 50 ns period
    always #25 clk = ~clk;
    fia_flash_iap #(.LARGE_VARIANT(1'b0)) u_dut (
        .core_clk_in(clk), .rst_n_in(rst_n), .slow_osc_tick_in(tick),
        .sfr_sector_in(sec), .sfr_addr_in(addr), .sfr_wr_in(wr), .sfr_wdata_in(wdata),
        .sfr_rdata_out(rdata), .flash_done_in(f_done), .flash_rdata_in(frdata),
        .flash_write_out(f_wr), .flash_erase_out(f_er), .flash_read_out(f_rd),
        .flash_addr_out(faddr), .flash_page_out(page), .flash_wdata_out(fwdata),
        .write_buf_clear_out(bclr), .chip_reset_out(crst), .cpu_stall_out(stall),
        .write_unlocked_out(unl));
    fia_flash_model u_flash (
        .core_clk_in(clk), .rst_n_in(rst_n), .flash_write_in(f_wr), .flash_erase_in(f_er),
        .flash_read_in(f_rd), .flash_done_out(f_done), .flash_rdata_out(frdata));
    ////////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic wrap_up();
        if (fails == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        tests_run++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            fails++;
        end
    endtask
    // one write strobe, held for exactly one taken edge
    task automatic wr_reg(input logic [3:0] s, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sec <= s; addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input string n, input logic [3:0] s, input logic [7:0] a,
                          input logic [7:0] e);
        @(posedge clk);
        sec <= s; addr <= a;
        repeat (2) @(posedge clk);
        #1 chk(n, {56'h0, e}, {56'h0, rdata});
    endtask
    // start the unlock, let n slow ticks pass, then send the pattern; byte bad is corrupted
    task automatic send_pattern(input int ticks, input int bad);
        wr_reg(4'h1, fia_pkg::ADDR_CTRL_MAIN, 8'h68);
        repeat (ticks) begin
            @(posedge clk) tick <= 1'b1;
            @(posedge clk) tick <= 1'b0;
        end
        for (int i = 0; i < 6; i++)
            wr_reg(4'h1, 8'(fia_pkg::ADDR_PATTERN_FIRST + i),
                   fia_pkg::UNLOCK_PATTERN[8*i +: 8] ^ ((i == bad) ? 8'hFF : 8'h00));
        @(posedge clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_regs();
        for (int i = 0; i < 6; i++) rd_chk("data reset", 4'h1, 8'h74 + 8'(i), 8'h00);
        for (int i = 0; i < 6; i++) wr_reg(4'h2, 8'h74 + 8'(i), 8'hA0 + 8'(i));
        for (int i = 0; i < 6; i++) rd_chk("data rw", 4'h3, 8'h74 + 8'(i), 8'hA0 + 8'(i));
        wr_reg(4'h3, fia_pkg::ADDR_CTRL_MAIN, 8'h33);
        rd_chk("ctrl other sector", 4'h3, fia_pkg::ADDR_CTRL_MAIN, 8'h00);
        rd_chk("ctrl sector one", 4'h1, fia_pkg::ADDR_CTRL_MAIN, 8'h00);
    endtask
    task automatic t_unlock();
        send_pattern(0, 2);
        chk("unlocked after bad byte", 64'h0, {63'h0, unl});
        rd_chk("enable cleared", 4'h1, fia_pkg::ADDR_CTRL_MAIN, 8'h60);
        send_pattern(9, 9);
        chk("unlocked after timeout", 64'h0, {63'h0, unl});
        send_pattern(8, 9);
        chk("unlocked in time", 64'h1, {63'h0, unl});
        rd_chk("ctrl after unlock", 4'h1, fia_pkg::ADDR_CTRL_MAIN, 8'hE0);
    endtask
    task automatic t_erase();
        int seen;
        seen = 0;
        wr_reg(4'h1, fia_pkg::ADDR_ADDR_LOW, 8'hA5);
        wr_reg(4'h1, fia_pkg::ADDR_ADDR_HIGH, 8'hE3);
        wr_reg(4'h1, fia_pkg::ADDR_CTRL_MAIN, 8'h94);
        repeat (10) begin
            @(posedge clk);
            #1 if (f_er === 1'b1 && seen == 0) seen = 1;
            if (seen == 1) break;
        end
        chk("erase launched", 64'h1, 64'(seen));
        chk("erase page", 64'h1D, {56'h0, page});
        chk("stall during erase", 64'h1, {63'h0, stall});
        repeat (20) begin
            @(posedge clk);
            #1 if (stall === 1'b0) break;
        end
        chk("stall released", 64'h0, {63'h0, stall});
        rd_chk("trigger cleared", 4'h1, fia_pkg::ADDR_CTRL_MAIN, 8'h90);
        // program write into the erased page; address and data words travel with it
        wr_reg(4'h1, fia_pkg::ADDR_CTRL_MAIN, 8'h84);
        seen = 0;
        repeat (20) begin
            @(posedge clk);
            #1 if (f_wr === 1'b1) seen++;
            if (stall === 1'b0) break;
        end
        chk("write launched", 64'h1, 64'(seen));
        chk("write address", 64'h03A5, {50'h0, faddr});
        chk("write data", {fia_pkg::UNLOCK_PATTERN, 16'h0000}, fwdata);
        chk("write stall released", 64'h0, {63'h0, stall});
    endtask
    task automatic t_relock();
        int hits;
        hits = 0;
        wr_reg(4'h1, fia_pkg::ADDR_CTRL_MAIN, 8'h00);
        @(posedge clk);
        #1 chk("relocked", 64'h0, {63'h0, unl});
        wr_reg(4'h1, fia_pkg::ADDR_CTRL_MAIN, 8'h84);
        repeat (8) begin
            @(posedge clk);
            #1 if (f_wr === 1'b1) hits++;
        end
        chk("software set of flag", 64'h0, {63'h0, unl});
        chk("locked write refused", 64'h0, 64'(hits));
        chk("refused stall gone", 64'h0, {63'h0, stall});
    endtask
    task automatic t_read();
        int hits;
        hits = 0;
        wr_reg(4'h1, fia_pkg::ADDR_CTRL_MAIN, 8'h33);
        repeat (20) begin
            @(posedge clk);
            #1 if (f_rd === 1'b1) hits++;
            if (stall === 1'b0) break;
        end
        chk("read launched", 64'h1, 64'(hits));
        chk("read stall released", 64'h0, {63'h0, stall});
        rd_chk("read low", 4'h1, fia_pkg::ADDR_DATA_FIRST, 8'hEF);
        rd_chk("read high", 4'h1, 8'h73, 8'hBE);
    endtask
    // one-cycle strobes, looked at just after the edge that launches them
    task automatic t_strobes();
        wr_reg(4'h1, fia_pkg::ADDR_CTRL_BUFCLR, 8'h01);
        #1 chk("buffer clear pulse", 64'h1, {63'h0, bclr});
        wr_reg(4'h2, fia_pkg::ADDR_CTRL_CHIPRST, fia_pkg::CHIP_RESET_KEY);
        #1 chk("chip reset other sector", 64'h0, {63'h0, crst});
        wr_reg(4'h1, fia_pkg::ADDR_CTRL_CHIPRST, fia_pkg::CHIP_RESET_KEY);
        #1 chk("chip reset pulse", 64'h1, {63'h0, crst});
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // main sequence and watchdog
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_unlock();
        t_erase();
        t_relock();
        t_read();
        t_strobes();
        wrap_up();
    end
    initial begin
        #(50 * 20000);
        fails++;
        wrap_up();
    end
endmodule // fia_flash_iap_tb
